// File: hw/adccr_top.sv
// converter channel register block: apb slave, result formatting, channel setup
// Function
// - upper calibration register holds calibration bits 11:8 in its bits 3:0
// - channel 0 result is one 16-bit value across low and high bytes
// - left-adjusted 12-bit: high byte carries result bits 11:4
// - left-adjusted 12-bit: low byte bits 7:4 carry result 3:0, rest zero
// - right-adjusted 12-bit: high byte 3:0 = bits 11:8, top sign in differential
// - 8-bit: high byte copies bit 7 when signed, else zero
// - right-adjusted and 8-bit: low byte carries result bits 7:0
// - high compare byte stores upper eight bits of 16-bit compare value
// - low compare byte stores lower eight bits of compare value
// - writing one to start begins a conversion; hardware clears it once started
// - writing start while already set queues nothing extra
// - channel start bit aliases the global channel 0 start bit
// - three-bit gain field selects 1x to 64x, code 111 one-half
// - changing input mode may corrupt data still in the pipeline
// - unsigned: mode 00 internal, 01 single-ended, 10 and 11 reserved
// - signed: 10 differential, 11 differential with gain
// - input select resets to zero: positive 6:3, negative 2:0, bit 7 reserved
// - internal mode: positive 0 temperature, 1 bandgap, 2 scaled supply
// - pin modes: positive code n selects analog input pin n
// - negative selection is ignored in internal and single-ended modes
// - differential: negative 0-3 pins 0-3, 101 pad ground, 111 internal ground
// - differential with gain: 0-3 pins 4-7, 100 internal ground, 111 pad ground
// - reading a result or compare low byte latches its high byte into the hold register
`timescale 1ns/100ps
module adccr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adccr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_started,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  output logic conv_start_req,
  output logic converter_enable,
  output logic pipeline_flush,
  output logic [11:0] calibration_value,
  output logic [15:0] compare_value,
  output logic [15:0] channel0_result,
  output logic signed_conversion_select,
  output adccr_pkg::adccr_res_t resolution,
  output adccr_pkg::adccr_gain_t gain_select,
  output adccr_pkg::adccr_mode_t input_mode_field,
  output logic [3:0] positive_input_select,
  output logic [2:0] negative_input_select,
  output logic route_legal,
  output logic positive_is_pin,
  output logic negative_used,
  output logic negative_is_pin,
  output logic [2:0] negative_pin,
  output logic negative_pad_ground,
  output logic internal_ground
);
  import adccr_pkg::*;

  typedef struct packed {
    logic enable;
    logic start;
    logic signed_sel;
    adccr_res_t res;
    logic [7:0] hold;
    logic [7:0] pend_high;
    logic [11:0] calibration;
    logic [15:0] result;
    logic [15:0] compare;
    adccr_gain_t gain;
    adccr_mode_t mode;
    logic [3:0] pos;
    logic [2:0] neg;
    logic flush;
    logic [7:0] rdata;
    logic err;
  } adccr_state_t;

  adccr_state_t s;
  adccr_state_t next_s;
  logic [7:0] idx;
  logic aligned;
  logic setup;
  logic write_done;
  logic read_done;
  logic mapped;
  logic [7:0] read_byte;
  logic [15:0] formatted;

  // bus phase decode; slave never stalls
  assign idx = {2'b00, paddr[ADDR_W-1:2]};
  assign aligned = paddr[1:0] == 2'b00;
  assign setup = psel & ~penable;
  assign write_done = psel & penable & pwrite;
  assign read_done = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & s.err;
  assign prdata = {24'h0, s.rdata};

  // register read map; high bytes of 16-bit pairs read the hold register
  always_comb
  begin
    mapped = aligned;
    read_byte = 8'h00;
    unique case (idx)
      IDX_GLOBAL_CONTROL:
        read_byte = {5'h0, s.start, 1'b0, s.enable};
      IDX_CONVERT_SETUP:
        read_byte = {3'h0, s.signed_sel, 1'b0, s.res, 1'b0};
      IDX_HOLD:
        read_byte = s.hold;
      IDX_CALIBRATION_LOW:
        read_byte = s.calibration[7:0];
      IDX_CALIBRATION_HIGH:
        read_byte = {4'h0, s.calibration[11:CAL_HIGH_LSB]};
      IDX_RESULT_LOW:
        read_byte = s.result[7:0];
      IDX_RESULT_HIGH, IDX_COMPARE_HIGH:
        read_byte = s.hold;
      IDX_COMPARE_LOW:
        read_byte = s.compare[7:0];
      IDX_CHANNEL_CONTROL:
        read_byte = {s.start, 2'b00, s.gain, s.mode};
      IDX_INPUT_SELECT:
        read_byte = {1'b0, s.pos, s.neg};
      default:
        mapped = 1'b0;
    endcase
  end

  adccr_result_fmt u_fmt (
    .raw(conv_data),
    .resolution(s.res),
    .signed_conversion_select(s.signed_sel),
    .input_mode_field(s.mode),
    .formatted(formatted)
  );

  adccr_input_route u_route (
    .input_mode_field(s.mode),
    .signed_conversion_select(s.signed_sel),
    .positive_input_select(s.pos),
    .negative_input_select(s.neg),
    .route_legal(route_legal),
    .positive_is_pin(positive_is_pin),
    .negative_used(negative_used),
    .negative_is_pin(negative_is_pin),
    .negative_pin(negative_pin),
    .negative_pad_ground(negative_pad_ground),
    .internal_ground(internal_ground)
  );

  // next-state: converter handshake, bus capture, register writes
  always_comb
  begin
    next_s = s;
    next_s.flush = 1'b0;
    // taking the request clears it; a simultaneous set is consumed by that start
    if (conv_started && s.start)
      next_s.start = 1'b0;
    // whole 16-bit word replaced at once, no mixed bytes
    if (conv_done)
      next_s.result = formatted;
    // read data and high byte snapshot captured in the setup cycle
    if (setup)
    begin
      next_s.rdata = mapped ? read_byte : 8'h00;
      next_s.err = ~mapped;
      next_s.pend_high = (idx == IDX_RESULT_LOW) ? s.result[15:8] : s.compare[15:8];
    end
    if (read_done && aligned && (idx == IDX_RESULT_LOW || idx == IDX_COMPARE_LOW))
      next_s.hold = s.pend_high;
    if (write_done && aligned)
    begin
      unique case (idx)
        IDX_GLOBAL_CONTROL:
        begin
          next_s.enable = pwdata[GLOBAL_ENABLE_BIT];
          if (pwdata[GLOBAL_START_BIT] && !s.start)
            next_s.start = 1'b1;
        end
        IDX_CONVERT_SETUP:
        begin
          next_s.signed_sel = pwdata[SETUP_SIGNED_BIT];
          next_s.res = adccr_res_t'(pwdata[SETUP_RES_LSB+:2]);
        end
        IDX_HOLD:
          next_s.hold = pwdata[7:0];
        IDX_CALIBRATION_LOW:
          next_s.calibration[7:0] = pwdata[7:0];
        IDX_CALIBRATION_HIGH:
          next_s.calibration[11:CAL_HIGH_LSB] = pwdata[3:0];
        IDX_COMPARE_LOW:
          next_s.compare[7:0] = pwdata[7:0];
        IDX_COMPARE_HIGH:
          next_s.compare[15:8] = pwdata[7:0];
        IDX_CHANNEL_CONTROL:
        begin
          if (pwdata[CHANNEL_START_BIT] && !s.start)
            next_s.start = 1'b1;
          next_s.gain = adccr_gain_t'(pwdata[CHANNEL_GAIN_LSB+:3]);
          next_s.mode = adccr_mode_t'(pwdata[CHANNEL_MODE_LSB+:2]);
          // a mode change invalidates in-flight samples, so flush the pipe
          next_s.flush = pwdata[CHANNEL_MODE_LSB+:2] != s.mode;
        end
        IDX_INPUT_SELECT:
        begin
          next_s.pos = pwdata[SELECT_POS_LSB+:4];
          next_s.neg = pwdata[SELECT_NEG_LSB+:3];
        end
        default:
          next_s.flush = 1'b0;
      endcase
    end
  end

  // all state in one register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s.enable <= 1'b0;
      s.start <= 1'b0;
      s.signed_sel <= 1'b0;
      s.res <= ADCCR_RES_RIGHT12;
      s.hold <= REG_RESET;
      s.pend_high <= REG_RESET;
      s.calibration <= 12'h000;
      s.result <= 16'h0000;
      s.compare <= 16'h0000;
      s.gain <= ADCCR_GAIN_1X;
      s.mode <= ADCCR_IN_INTERNAL;
      s.pos <= INPUT_SELECT_RESET[SELECT_POS_LSB+:4];
      s.neg <= INPUT_SELECT_RESET[SELECT_NEG_LSB+:3];
      s.flush <= 1'b0;
      s.rdata <= REG_RESET;
      s.err <= 1'b0;
    end
    else
      s <= next_s;
  end

  // converter-facing outputs straight from the state register
  assign conv_start_req = s.start;
  assign converter_enable = s.enable;
  assign pipeline_flush = s.flush;
  assign calibration_value = s.calibration;
  assign compare_value = s.compare;
  assign channel0_result = s.result;
  assign signed_conversion_select = s.signed_sel;
  assign resolution = s.res;
  assign gain_select = s.gain;
  assign input_mode_field = s.mode;
  assign positive_input_select = s.pos;
  assign negative_input_select = s.neg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence q_write(logic [7:0] a);
    setup && pwrite && aligned && idx == a ##1 write_done;
  endsequence
  sequence q_low_read;
    setup && !pwrite && aligned && idx == IDX_RESULT_LOW ##1 read_done;
  endsequence

  property p_calibration_high;
    q_write(IDX_CALIBRATION_HIGH) |=> calibration_value[11:8] == $past(pwdata[3:0]);
  endproperty
  a_calibration_high: assert property (p_calibration_high) else $error("calibration high not stored");

  property p_left_adjust;
    conv_done && s.res == ADCCR_RES_LEFT12 |=> channel0_result == {$past(conv_data), 4'h0};
  endproperty
  a_left_adjust: assert property (p_left_adjust) else $error("left adjusted result wrong");

  property p_right_sign;
    conv_done && s.res == ADCCR_RES_RIGHT12 && s.signed_sel && s.mode[1]
      |=> channel0_result == {{4{$past(conv_data[11])}}, $past(conv_data)};
  endproperty
  a_right_sign: assert property (p_right_sign) else $error("right adjusted sign copy wrong");

  property p_eight_unsigned;
    conv_done && s.res == ADCCR_RES_EIGHT && !s.signed_sel
      |=> channel0_result == {8'h00, $past(conv_data[7:0])};
  endproperty
  a_eight_unsigned: assert property (p_eight_unsigned) else $error("8-bit result wrong");

  // each location has its own start bit position; bit 2 of channel control is gain
  property p_start_set;
    ((q_write(IDX_CHANNEL_CONTROL) ##0 pwdata[CHANNEL_START_BIT])
      or (q_write(IDX_GLOBAL_CONTROL) ##0 pwdata[GLOBAL_START_BIT]))
      ##0 !conv_start_req && !conv_started |=> conv_start_req;
  endproperty
  a_start_set: assert property (p_start_set) else $error("start write ignored");

  property p_start_clear;
    conv_start_req && conv_started |=> !conv_start_req;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start not cleared");

  property p_flush;
    q_write(IDX_CHANNEL_CONTROL) ##0 pwdata[1:0] != input_mode_field |=> pipeline_flush ##1 !pipeline_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("mode change gave no one-cycle flush");

  property p_negative_ignored;
    !input_mode_field[1] |-> !negative_used && !negative_is_pin && !internal_ground && !negative_pad_ground;
  endproperty
  a_negative_ignored: assert property (p_negative_ignored) else $error("negative used outside differential");

  property p_hold_latch;
    q_low_read |=> s.hold == $past(channel0_result[15:8], 2);
  endproperty
  a_hold_latch: assert property (p_hold_latch) else $error("hold not latched on low read");

  property p_atomic_result;
    !$stable(channel0_result) |-> $past(conv_done);
  endproperty
  a_atomic_result: assert property (p_atomic_result) else $error("result changed without completion");

  property p_compare_low;
    q_write(IDX_COMPARE_LOW) |=> compare_value[7:0] == $past(pwdata[7:0]);
  endproperty
  a_compare_low: assert property (p_compare_low) else $error("compare low not stored");
endmodule : adccr_top

// File: hw/adccr_pkg.sv
// package: register map, field layout and encodings of the converter channel block
package adccr_pkg;
  localparam int ADDR_W = 8;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_GLOBAL_CONTROL = 8'h00;
  localparam logic [7:0] IDX_CONVERT_SETUP = 8'h01;
  localparam logic [7:0] IDX_HOLD = 8'h07;
  localparam logic [7:0] IDX_CALIBRATION_LOW = 8'h0c;
  localparam logic [7:0] IDX_CALIBRATION_HIGH = 8'h0d;
  localparam logic [7:0] IDX_RESULT_LOW = 8'h10;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h11;
  localparam logic [7:0] IDX_COMPARE_LOW = 8'h18;
  localparam logic [7:0] IDX_COMPARE_HIGH = 8'h19;
  localparam logic [7:0] IDX_CHANNEL_CONTROL = 8'h20;
  localparam logic [7:0] IDX_INPUT_SELECT = 8'h21;
  // field positions
  localparam int GLOBAL_ENABLE_BIT = 0;
  localparam int GLOBAL_START_BIT = 2;
  localparam int SETUP_RES_LSB = 1;
  localparam int SETUP_SIGNED_BIT = 4;
  localparam int CHANNEL_START_BIT = 7;
  localparam int CHANNEL_GAIN_LSB = 2;
  localparam int CHANNEL_MODE_LSB = 0;
  localparam int SELECT_POS_LSB = 3;
  localparam int SELECT_NEG_LSB = 0;
  localparam int CAL_HIGH_LSB = 8;
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
  typedef enum logic [1:0] {
    ADCCR_RES_RIGHT12 = 2'b00,
    ADCCR_RES_EIGHT = 2'b10,
    ADCCR_RES_LEFT12 = 2'b11
  } adccr_res_t;
  typedef enum logic [1:0] {
    ADCCR_IN_INTERNAL = 2'b00,
    ADCCR_IN_SINGLE_ENDED = 2'b01,
    ADCCR_IN_DIFFERENTIAL = 2'b10,
    ADCCR_IN_DIFFERENTIAL_GAIN = 2'b11
  } adccr_mode_t;
  typedef enum logic [2:0] {
    ADCCR_GAIN_1X = 3'h0,
    ADCCR_GAIN_2X = 3'h1,
    ADCCR_GAIN_4X = 3'h2,
    ADCCR_GAIN_8X = 3'h3,
    ADCCR_GAIN_16X = 3'h4,
    ADCCR_GAIN_32X = 3'h5,
    ADCCR_GAIN_64X = 3'h6,
    ADCCR_GAIN_HALF = 3'h7
  } adccr_gain_t;
  // positive internal sources and negative selection codes
  localparam logic [3:0] POS_TEMPERATURE = 4'h0;
  localparam logic [3:0] POS_BANDGAP = 4'h1;
  localparam logic [3:0] POS_SCALED_SUPPLY = 4'h2;
  localparam logic [2:0] NEG_PIN_LAST = 3'h3;
  localparam logic [2:0] NEG_PLAIN_PAD_GROUND = 3'h5;
  localparam logic [2:0] NEG_PLAIN_INTERNAL_GROUND = 3'h7;
  localparam logic [2:0] NEG_GAIN_INTERNAL_GROUND = 3'h4;
  localparam logic [2:0] NEG_GAIN_PAD_GROUND = 3'h7;
endpackage : adccr_pkg

// File: hw/adccr_result_fmt.sv
// result formatter: places a raw conversion into the 16-bit result pair
`timescale 1ns/100ps
module adccr_result_fmt (
  input wire logic [11:0] raw,
  input wire adccr_pkg::adccr_res_t resolution,
  input wire logic signed_conversion_select,
  input wire adccr_pkg::adccr_mode_t input_mode_field,
  output logic [15:0] formatted
);
  import adccr_pkg::*;
  logic result_bit_eleven;
  logic result_bit_seven;

  // sign copies; bit eleven zero unless signed differential, bit seven zero unless signed
  assign result_bit_eleven = signed_conversion_select & input_mode_field[1] & raw[11];
  assign result_bit_seven = signed_conversion_select & raw[7];

  // reserved resolution code falls back to right-adjusted
  always_comb
  begin
    unique case (resolution)
      ADCCR_RES_LEFT12: formatted = {raw, 4'h0};
      ADCCR_RES_EIGHT: formatted = {{8{result_bit_seven}}, raw[7:0]};
      default: formatted = {{4{result_bit_eleven}}, raw};
    endcase
  end
endmodule : adccr_result_fmt

// File: hw/adccr_input_route.sv
// input routing decode: turns mode and selections into analog switch controls
`timescale 1ns/100ps
module adccr_input_route (
  input wire adccr_pkg::adccr_mode_t input_mode_field,
  input wire logic signed_conversion_select,
  input wire logic [3:0] positive_input_select,
  input wire logic [2:0] negative_input_select,
  output logic route_legal,
  output logic positive_is_pin,
  output logic negative_used,
  output logic negative_is_pin,
  output logic [2:0] negative_pin,
  output logic negative_pad_ground,
  output logic internal_ground
);
  import adccr_pkg::*;

  // negative side only matters in the two differential modes
  always_comb
  begin
    route_legal = 1'b1;
    positive_is_pin = 1'b0;
    negative_used = 1'b0;
    negative_is_pin = 1'b0;
    negative_pin = 3'h0;
    negative_pad_ground = 1'b0;
    internal_ground = 1'b0;
    unique case (input_mode_field)
      ADCCR_IN_INTERNAL:
        route_legal = positive_input_select <= POS_SCALED_SUPPLY;
      ADCCR_IN_SINGLE_ENDED:
        positive_is_pin = 1'b1;
      ADCCR_IN_DIFFERENTIAL:
      begin
        positive_is_pin = 1'b1;
        negative_used = 1'b1;
        route_legal = signed_conversion_select;
        negative_pin = {1'b0, negative_input_select[1:0]};
        if (negative_input_select <= NEG_PIN_LAST)
          negative_is_pin = 1'b1;
        else if (negative_input_select == NEG_PLAIN_PAD_GROUND)
          negative_pad_ground = 1'b1;
        else if (negative_input_select == NEG_PLAIN_INTERNAL_GROUND)
          internal_ground = 1'b1;
        else
          route_legal = 1'b0;
      end
      ADCCR_IN_DIFFERENTIAL_GAIN:
      begin
        positive_is_pin = 1'b1;
        negative_used = 1'b1;
        route_legal = signed_conversion_select;
        negative_pin = {1'b1, negative_input_select[1:0]};
        if (negative_input_select <= NEG_PIN_LAST)
          negative_is_pin = 1'b1;
        else if (negative_input_select == NEG_GAIN_INTERNAL_GROUND)
          internal_ground = 1'b1;
        else if (negative_input_select == NEG_GAIN_PAD_GROUND)
          negative_pad_ground = 1'b1;
        else
          route_legal = 1'b0;
      end
    endcase
  end
endmodule : adccr_input_route

// File: dv/adccr_top_tb_top.sv
// self-checking bench for the converter channel register block
`timescale 1ns/100ps
module adccr_top_tb_top;
  import adccr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic conv_started, conv_done, conv_start_req, converter_enable, pipeline_flush;
  logic [11:0] conv_data, calibration_value;
  logic [15:0] compare_value, channel0_result;
  logic signed_conversion_select;
  adccr_res_t resolution;
  adccr_gain_t gain_select;
  adccr_mode_t input_mode_field;
  logic [3:0] positive_input_select;
  logic [2:0] negative_input_select, negative_pin;
  logic route_legal, positive_is_pin, negative_used, negative_is_pin, negative_pad_ground, internal_ground;
  int n_mismatch, checks_done, cycles, nf;
  logic [33:0] expq[$];
  logic [33:0] note;
  logic [31:0] seed = 32'h62f75f0f;
  logic [31:0] x;
  logic [15:0] e;
  logic [11:0] d;
  logic [7:0] ctrl;
  logic [1:0] rc, mc;
  logic sgn;

  adccr_top u_adccr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .conv_started, .conv_done, .conv_data, .conv_start_req, .converter_enable, .pipeline_flush,
    .calibration_value, .compare_value, .channel0_result, .signed_conversion_select, .resolution,
    .gain_select, .input_mode_field, .positive_input_select, .negative_input_select, .route_legal,
    .positive_is_pin, .negative_used, .negative_is_pin, .negative_pin, .negative_pad_ground,
    .internal_ground);

  // 100 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // apb master; the expectation is queued before the transfer starts
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] dt, input logic er,
                     input logic [7:0] ex);
    logic [31:0] r;
    r = rnd();
    expq.push_back({~w, er, 24'h0, ex});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {r[31:8], dt};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    apb(1'b1, a, dt, 1'b0, 8'h00);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    apb(1'b0, a, 8'h00, 1'b0, ex);
  endtask : rd

  // one conversion ends; data is scrambled once it is no longer valid
  task automatic conv(input logic [11:0] v);
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_data <= v;
    @(posedge pclk);
    conv_done <= 1'b0;
    conv_data <= ~v;
    @(negedge pclk);
  endtask : conv

  task automatic started();
    @(posedge pclk);
    conv_started <= 1'b1;
    @(posedge pclk);
    conv_started <= 1'b0;
    @(negedge pclk);
  endtask : started

  // counts flush pulses over the three cycles after a write
  task automatic flushes(output int n);
    n = 0;
    repeat (3)
    begin
      @(posedge pclk);
      n += int'(pipeline_flush === 1'b1);
    end
  endtask : flushes

  // signed/mode/selection setup, then masked compare of the decode outputs
  task automatic route(input logic s, input logic [1:0] m, input logic [6:0] sel, input logic [5:0] ex,
                       input logic [5:0] k);
    wr(8'h04, {3'b0, s, 4'b0});
    wr(8'h80, {6'b0, m});
    wr(8'h84, {1'b0, sel});
    @(negedge pclk);
    chk({26'h0, {route_legal, positive_is_pin, negative_used, negative_is_pin, negative_pad_ground,
      internal_ground} & k}, {26'h0, ex & k});
  endtask : route

  // watcher: every completed transfer takes the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready)
    begin
      if (expq.size() == 0)
        chk(32'h0, 32'h1);
      else
      begin
        // own variable: the stimulus keeps its random word in x across transfers
        note = expq.pop_front();
        chk({31'h0, pslverr}, {31'h0, note[32]});
        if (note[33])
          chk(prdata, note[31:0]);
      end
    end
  end

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, conv_started, conv_done} = 6'h0;
    paddr = '0;
    pwdata = 32'h0;
    conv_data = 12'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h84, 8'h00);
    wr(8'h84, 8'hff);
    rd(8'h84, 8'h7f);
    @(negedge pclk);
    chk({25'h0, positive_input_select, negative_input_select}, 32'h7f);
    apb(1'b0, 8'h08, 8'h00, 1'b1, 8'h00);
    apb(1'b1, 8'h31, 8'h5a, 1'b1, 8'h00);
    // calibration pair and compare pair with a snapshot hold
    x = rnd();
    wr(8'h30, x[7:0]);
    wr(8'h34, x[15:8]);
    @(negedge pclk);
    chk({20'h0, calibration_value}, {20'h0, x[11:0]});
    rd(8'h34, {4'h0, x[11:8]});
    wr(8'h60, x[23:16]);
    wr(8'h64, x[31:24]);
    @(negedge pclk);
    chk({16'h0, compare_value}, {16'h0, x[31:16]});
    rd(8'h60, x[23:16]);
    wr(8'h64, ~x[31:24]);
    rd(8'h64, x[31:24]);
    rd(8'h1c, x[31:24]);
    // every resolution against unsigned, signed single-ended and differential
    for (int r = 0; r < 3; r++)
      for (int m = 0; m < 3; m++)
      begin
        rc = (r == 0) ? 2'b00 : (r == 1) ? 2'b10 : 2'b11;
        mc = (m == 2) ? 2'b10 : 2'b01;
        sgn = (m != 0);
        x = rnd();
        d = {x[11] ^ r[0], x[10:8], m[0], x[6:0]};
        e = (rc == 2'b11) ? {d, 4'h0} : (rc == 2'b10) ? {{8{d[7] & sgn}}, d[7:0]} :
          {{4{d[11] & sgn & mc[1]}}, d};
        wr(8'h04, {3'b0, sgn, 1'b0, rc, 1'b0});
        wr(8'h80, {6'b0, mc});
        @(negedge pclk);
        chk({27'h0, signed_conversion_select, resolution, input_mode_field}, {27'h0, sgn, rc, mc});
        conv(d);
        chk({16'h0, channel0_result}, {16'h0, e});
        rd(8'h40, e[7:0]);
        conv(~d);
        rd(8'h44, e[15:8]);
      end
    // a change of input mode pulses flush once, a rewrite of the same mode not at all
    wr(8'h80, 8'h01);
    flushes(nf);
    chk(32'(nf), 32'h1);
    wr(8'h80, 8'h01);
    flushes(nf);
    chk(32'(nf), 32'h0);
    for (int g = 0; g < 8; g++)
    begin
      ctrl = {3'b0, g[2:0], 2'b01};
      wr(8'h80, ctrl);
      @(negedge pclk);
      chk({29'h0, gain_select}, {29'h0, g[2:0]});
      rd(8'h80, ctrl);
    end
    // start through the channel bit, second write while pending, then the global alias
    wr(8'h80, ctrl | 8'h80);
    @(negedge pclk);
    chk({31'h0, conv_start_req}, 32'h1);
    rd(8'h00, 8'h04);
    wr(8'h80, ctrl | 8'h80);
    started();
    chk({31'h0, conv_start_req}, 32'h0);
    repeat (4) @(posedge pclk);
    rd(8'h80, ctrl);
    wr(8'h00, 8'h05);
    @(negedge pclk);
    chk({30'h0, converter_enable, conv_start_req}, 32'h3);
    rd(8'h80, ctrl | 8'h80);
    started();
    rd(8'h00, 8'h01);
    // input routing decode, one line per table corner
    route(1'b1, 2'b00, {4'h2, 3'h0}, 6'b100000, 6'b110000);
    route(1'b1, 2'b00, {4'h3, 3'h0}, 6'b000000, 6'b100000);
    route(1'b0, 2'b10, {4'h1, 3'h0}, 6'b000000, 6'b100000);
    route(1'b0, 2'b01, {4'h9, 3'h5}, 6'b110000, 6'b111000);
    route(1'b1, 2'b10, {4'h4, 3'h3}, 6'b111100, 6'b111111);
    chk({29'h0, negative_pin}, 32'h3);
    route(1'b1, 2'b10, {4'h4, 3'h5}, 6'b111010, 6'b111111);
    route(1'b1, 2'b10, {4'h4, 3'h7}, 6'b111001, 6'b111111);
    route(1'b1, 2'b10, {4'h4, 3'h4}, 6'b000000, 6'b100000);
    route(1'b1, 2'b11, {4'hf, 3'h2}, 6'b111100, 6'b111111);
    chk({29'h0, negative_pin}, 32'h6);
    route(1'b1, 2'b11, {4'hf, 3'h4}, 6'b111001, 6'b111111);
    route(1'b1, 2'b11, {4'hf, 3'h7}, 6'b111010, 6'b111111);
    route(1'b1, 2'b11, {4'hf, 3'h5}, 6'b000000, 6'b100000);
    repeat (2) @(posedge pclk);
    end_of_test();
  end
endmodule : adccr_top_tb_top
